/* logic/fecr_ctrl.sv */
// Purpose: Fuser heater regulation, warm-up, recovery and cleaning routines with a Wishbone register port.
// Assumes: Sensor inputs are synchronous to core_clk and active high as named.
// Notes: Routine lengths are parameters so a simulation can shorten them.
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
module fecr_ctrl
    import fecr_pkg::*;
#(
    parameter int unsigned RECOVER_CYCLES = RECOVER_CYC,
    parameter int unsigned CLEAN_CYCLES = CLEAN_CYC
)
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Thermistor code and paper path sensors.
    input wire logic [7:0] temp_code,
    input wire logic interlock_closed,
    input wire logic cassette_present,
    input wire logic exit_actuated,
    input wire logic reg_actuated,
    input wire logic cartridge_unit_switch,
    // Print controller status.
    input wire logic print_active,
    input wire logic continuous_print,
    // Engine drives.
    output logic heater_on,
    output logic main_motor_on,
    output logic charge_voltage_on,
    output logic transfer_voltage_on,
    output logic ready
);

    typedef struct packed {
        fecr_rt_t rt;
        logic [31:0] cnt;
        logic recov_pend;
        logic clean_pend;
        logic clean_warm;
        logic warm_done;
        logic warm_seen;
        logic warmup;
        logic heater;
        logic motor;
        logic charge;
        logic transfer;
        logic ready;
        logic por;
        logic ilk_q;
        logic cas_q;
        logic exit_q;
        logic cart_q;
        logic print_q;
        logic busy;
        logic ack;
        logic ctrl_en;
        logic ctrl_mode;
        logic [31:0] dat;
    } fecr_st_t;

    // All state except the setpoint memory lives in one packed record so that one register process holds it.
    fecr_st_t st_ff;
    fecr_st_t nxt_st;

    logic [MEM_WORDS-1:0][7:0] words;
    logic [7:0] mem_rd;
    logic mem_wr;
    logic [1:0] mem_idx;

    // Low threshold code: higher code means colder, saturating at the top code.
    function automatic logic [7:0] low_code(input logic [7:0] sp);
        logic [8:0] sum;
        sum = {1'b0, sp} + {1'b0, LOW_OFFSET_CODE};
        low_code = sum[8] ? CODE_MAX : sum[7:0];
    endfunction

    // True when the byte address falls in the setpoint memory window.
    function automatic logic in_mem(input logic [7:0] adr);
        in_mem = (adr >= ADDR_MEM_BASE) && (adr <= ADDR_MEM_LAST) && (adr[1:0] == 2'h0);
    endfunction

    // Memory index from a byte address in the window.
    function automatic logic [1:0] mem_index(input logic [7:0] adr);
        logic [7:0] off;
        off = adr - ADDR_MEM_BASE;
        mem_index = off[3:2];
    endfunction

    // True while a routine that needs the motor and high voltage is running.
    function automatic logic hv_state(input fecr_rt_t rt);
        hv_state = (rt == RT_RECOVER) || (rt == RT_CLEAN);
    endfunction

    // Memory writes land on the acknowledging edge, like the other registers.
    assign mem_idx = mem_index(wb_adr_i);
    assign mem_wr = st_ff.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && in_mem(wb_adr_i);

    fecr_cfg_mem u_mem (
        .core_clk(core_clk),
        .resetn(resetn),
        .wr_en(mem_wr),
        .wr_idx(mem_idx),
        .wr_data(wb_dat_i[7:0]),
        .rd_idx(mem_idx),
        .rd_data_ff(mem_rd),
        .words_ff(words)
    );

    always_comb begin
        logic [7:0] sp_code;
        logic [7:0] lo_code;
        logic run_sel;
        logic overheat;
        logic subcool;
        logic path_ok;
        logic interrupt;
        logic restore;
        logic print_end;
        logic cart_on;
        logic req;
        logic [31:0] status;
        logic warm_req;
        logic wr_ok;
        sp_code = 8'h00;
        lo_code = 8'h00;
        run_sel = 1'b0;
        overheat = 1'b0;
        subcool = 1'b0;
        path_ok = 1'b0;
        interrupt = 1'b0;
        restore = 1'b0;
        print_end = 1'b0;
        cart_on = 1'b0;
        req = 1'b0;
        status = 32'h0000_0000;
        warm_req = 1'b0;
        wr_ok = 1'b0;
        nxt_st = st_ff;

        // Sensor history for edge detection.
        // Interlock and cassette history reset low, so the first edge after reset also reads as a restore.
        // That restore coincides with power-on, which is a restore event already.
        nxt_st.por = 1'b0;
        nxt_st.ilk_q = interlock_closed;
        nxt_st.cas_q = cassette_present;
        nxt_st.exit_q = exit_actuated;
        nxt_st.cart_q = cartridge_unit_switch;
        nxt_st.print_q = print_active;

        // Setpoint selection and threshold codes.
        // The routine state is read, so the running setpoint starts one edge into recovery.
        run_sel = print_active || (st_ff.rt == RT_RECOVER);
        sp_code = run_sel ? words[MEM_RUNNING] : words[MEM_STANDBY];
        lo_code = low_code(sp_code);
        overheat = temp_code <= words[MEM_OVERHEAT];
        subcool = temp_code >= words[MEM_SUBCOOL];

        // Heater hysteresis; cold codes are large.
        // Overheat forces the heater off without latching, and a cleared enable holds it off.
        if (!st_ff.ctrl_en || overheat) begin
            nxt_st.heater = 1'b0;
        end else if (temp_code >= lo_code) begin
            nxt_st.heater = 1'b1;
        end else if (temp_code <= sp_code) begin
            nxt_st.heater = 1'b0;
        end

        // Warm-up starts at the first heater turn-on and ends at standby temperature.
        if (nxt_st.heater && !st_ff.warm_seen) begin
            nxt_st.warm_seen = 1'b1;
            nxt_st.warmup = 1'b1;
        end else if (st_ff.warmup && (temp_code <= words[MEM_STANDBY])) begin
            nxt_st.warmup = 1'b0;
        end

        // Paper path events.
        // The exit sensor interrupts as it rises; its clearing is not a restore event.
        path_ok = interlock_closed && cassette_present && !exit_actuated;
        interrupt = (st_ff.ilk_q && !interlock_closed) || (st_ff.cas_q && !cassette_present)
            || (!st_ff.exit_q && exit_actuated);
        restore = st_ff.por || (!st_ff.ilk_q && interlock_closed) || (!st_ff.cas_q && cassette_present);
        print_end = st_ff.print_q && !print_active && !continuous_print;
        cart_on = !st_ff.cart_q && cartridge_unit_switch;

        // Recovery requests; a blocked path at restore time cancels it.
        if (interrupt || st_ff.por) begin
            nxt_st.recov_pend = 1'b1;
        end
        if (restore && (exit_actuated || reg_actuated)) begin
            nxt_st.recov_pend = 1'b0;
        end

        // Cleaning requests.
        warm_req = (st_ff.por || cart_on) && st_ff.ctrl_mode;
        if (warm_req) begin
            nxt_st.clean_pend = 1'b1;
            nxt_st.clean_warm = 1'b1;
            nxt_st.warm_done = 1'b0;
        end
        if (print_end) begin
            nxt_st.clean_pend = 1'b1;
        end

        // Routine sequencer.
        // Recovery outranks cleaning; a lost path re-arms recovery but parks cleaning in halt.
        unique case (st_ff.rt)
            RT_IDLE: begin
                nxt_st.cnt = 32'h0000_0000;
                if (path_ok && nxt_st.recov_pend) begin
                    nxt_st.rt = RT_RECOVER;
                    nxt_st.recov_pend = 1'b0;
                end else if (path_ok && st_ff.clean_pend && !print_active) begin
                    nxt_st.rt = RT_CLEAN;
                end
            end
            RT_RECOVER: begin
                nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
                if (!path_ok) begin
                    nxt_st.rt = RT_IDLE;
                    nxt_st.recov_pend = 1'b1;
                end else if (st_ff.cnt == 32'(RECOVER_CYCLES - 1)) begin
                    nxt_st.rt = RT_IDLE;
                end
            end
            RT_CLEAN: begin
                nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
                if (!path_ok) begin
                    nxt_st.rt = RT_HALT;
                end else if (st_ff.cnt == 32'(CLEAN_CYCLES - 1)) begin
                    nxt_st.rt = RT_IDLE;
                    // A warm-clean request in the final cycle survives the completion.
                    nxt_st.clean_pend = print_end || warm_req;
                    if (st_ff.clean_warm && !warm_req) begin
                        nxt_st.warm_done = 1'b1;
                    end
                    nxt_st.clean_warm = warm_req;
                end
            end
            RT_HALT: begin
                nxt_st.cnt = 32'h0000_0000;
                if (path_ok) begin
                    nxt_st.rt = RT_CLEAN;
                end
            end
        endcase

        // Engine drives follow the next state so they track routine changes.
        nxt_st.motor = nxt_st.warmup || print_active || hv_state(nxt_st.rt);
        nxt_st.charge = hv_state(nxt_st.rt);
        nxt_st.transfer = hv_state(nxt_st.rt);
        // Ready also waits out a pending warm clean so the host never sees it mid-routine.
        nxt_st.ready = (nxt_st.warm_done || !st_ff.ctrl_mode) && nxt_st.warm_seen && !nxt_st.warmup
            && !overheat && !nxt_st.clean_warm;

        // Status word.
        status[ST_TEMP_LSB +: 8] = temp_code;
        status[ST_HEATER_BIT] = st_ff.heater;
        status[ST_WARMUP_BIT] = st_ff.warmup;
        status[ST_READY_BIT] = st_ff.ready;
        status[ST_OVERHEAT_BIT] = overheat;
        status[ST_SUBCOOL_BIT] = subcool;
        status[ST_RECOVER_BIT] = st_ff.rt == RT_RECOVER;
        status[ST_CLEAN_BIT] = st_ff.rt == RT_CLEAN;
        status[ST_HALT_BIT] = st_ff.rt == RT_HALT;
        status[ST_MOTOR_BIT] = st_ff.motor;
        status[ST_WARMDONE_BIT] = st_ff.warm_done;

        // Bus: take at one edge, answer at the next, drop ack after one cycle.
        // A request is refused while busy or acknowledging, so accesses never overlap.
        // Unmapped addresses and all writes answer with zero data.
        req = wb_cyc_i && wb_stb_i && !st_ff.busy && !st_ff.ack;
        nxt_st.busy = req;
        nxt_st.ack = st_ff.busy;
        if (st_ff.busy) begin
            nxt_st.dat = 32'h0000_0000;
            if (!wb_we_i) begin
                if (wb_adr_i == ADDR_CTRL) begin
                    nxt_st.dat[CTRL_EN_BIT] = st_ff.ctrl_en;
                    nxt_st.dat[CTRL_MODE_BIT] = st_ff.ctrl_mode;
                end else if (wb_adr_i == ADDR_STATUS) begin
                    nxt_st.dat = status;
                end else if (in_mem(wb_adr_i)) begin
                    nxt_st.dat[7:0] = mem_rd;
                end
            end
        end
        // Writes land on the edge at which the master samples ack, while its request still stands.
        wr_ok = st_ff.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
        if (wr_ok && (wb_adr_i == ADDR_CTRL)) begin
            nxt_st.ctrl_en = wb_dat_i[CTRL_EN_BIT];
            nxt_st.ctrl_mode = wb_dat_i[CTRL_MODE_BIT];
        end
    end

    // The power-on flag marks the first edge after release and clears itself.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
            st_ff.rt <= RT_IDLE;
            st_ff.por <= 1'b1;
            st_ff.ctrl_en <= CTRL_EN_RST;
            st_ff.ctrl_mode <= CTRL_MODE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign heater_on = st_ff.heater;
    assign main_motor_on = st_ff.motor;
    assign charge_voltage_on = st_ff.charge;
    assign transfer_voltage_on = st_ff.transfer;
    assign ready = st_ff.ready;

endmodule // fecr_ctrl

/* logic/fecr_pkg.sv */
// Purpose: Shared constants and types for the fuser and engine routine controller.
// Assumes: 10 MHz core clock; classic Wishbone with 8-bit byte address and 32-bit data.
// Notes: Temperature codes fall as the heat roll gets hotter.
package fecr_pkg;

    // Clock rate and routine times.
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned RECOVER_MS = 2000;
    localparam int unsigned CLEAN_MS = 3000;
    localparam int unsigned RECOVER_CYC = RECOVER_MS * (CLK_HZ / 1000);
    localparam int unsigned CLEAN_CYC = CLEAN_MS * (CLK_HZ / 1000);

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MEM_BASE = 8'h08;
    localparam logic [7:0] ADDR_MEM_LAST = 8'h14;

    // Setpoint memory words.
    localparam int MEM_WORDS = 4;
    localparam logic [1:0] MEM_STANDBY = 2'h0;
    localparam logic [1:0] MEM_RUNNING = 2'h1;
    localparam logic [1:0] MEM_OVERHEAT = 2'h2;
    localparam logic [1:0] MEM_SUBCOOL = 2'h3;

    // Reset codes: 160 C, about 166 C, about 205 C, 145 C.
    localparam logic [7:0] STANDBY_RST = 8'hac;
    localparam logic [7:0] RUNNING_RST = 8'ha4;
    localparam logic [7:0] OVERHEAT_RST = 8'h6e;
    localparam logic [7:0] SUBCOOL_RST = 8'hc0;

    // About 2 C expressed in code steps near the setpoint.
    localparam logic [7:0] LOW_OFFSET_CODE = 8'h03;
    localparam logic [7:0] CODE_MAX = 8'hff;

    // Control register fields and reset values.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic CTRL_MODE_RST = 1'b1;

    // Status register fields.
    localparam int ST_TEMP_LSB = 0;
    localparam int ST_HEATER_BIT = 8;
    localparam int ST_WARMUP_BIT = 9;
    localparam int ST_READY_BIT = 10;
    localparam int ST_OVERHEAT_BIT = 11;
    localparam int ST_SUBCOOL_BIT = 12;
    localparam int ST_RECOVER_BIT = 13;
    localparam int ST_CLEAN_BIT = 14;
    localparam int ST_HALT_BIT = 15;
    localparam int ST_MOTOR_BIT = 16;
    localparam int ST_WARMDONE_BIT = 17;

    typedef enum logic [3:0] {
        RT_IDLE = 4'h1,
        RT_RECOVER = 4'h2,
        RT_CLEAN = 4'h4,
        RT_HALT = 4'h8
    } fecr_rt_t;

endpackage

/* logic/fecr_cfg_mem.sv */
// Purpose: Small setpoint and limit memory for the fuser controller.
// Assumes: One write port and one registered read port, both on core_clk.
// Notes: All words are also presented live so the heater comparators see them every cycle.
`timescale 1ns/10ps
module fecr_cfg_mem
    import fecr_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // Write port.
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [7:0] wr_data,
    // Read port.
    input wire logic [1:0] rd_idx,
    output logic [7:0] rd_data_ff,
    // Live words.
    output logic [MEM_WORDS-1:0][7:0] words_ff
);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            words_ff[MEM_STANDBY] <= STANDBY_RST;
            words_ff[MEM_RUNNING] <= RUNNING_RST;
            words_ff[MEM_OVERHEAT] <= OVERHEAT_RST;
            words_ff[MEM_SUBCOOL] <= SUBCOOL_RST;
            rd_data_ff <= 8'h00;
        end else begin
            if (wr_en) begin
                words_ff[wr_idx] <= wr_data;
            end
            rd_data_ff <= words_ff[rd_idx];
        end
    end

endmodule // fecr_cfg_mem

/* dv/fecr_ctrl_props.sv */
// Purpose: Concurrent checks on the fuser and engine routine controller ports.
// Assumes: One clock domain; routine lengths match the bound instance.
// Notes: Bound to every instance of the controller.
`timescale 1ns/10ps
module fecr_ctrl_props
    import fecr_pkg::*;
#(
    parameter int unsigned RECOVER_CYCLES = 20,
    parameter int unsigned CLEAN_CYCLES = 30
)
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // Bus handshake.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Sensors.
    input wire logic [7:0] temp_code,
    input wire logic interlock_closed,
    // Engine drives.
    input wire logic heater_on,
    input wire logic main_motor_on,
    input wire logic charge_voltage_on,
    input wire logic transfer_voltage_on,
    input wire logic ready
);
    logic [31:0] run_ff;
    // Counts how long the high voltage has stayed on without a break.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            run_ff <= 32'h0;
        end else begin
            run_ff <= charge_voltage_on ? run_ff + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !$past(wb_stb_i);
    endsequence
    sequence s_open;
        $fell(interlock_closed);
    endsequence
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_in_time: assert property (s_req |-> ##[1:3] wb_ack_o)
        else $error("request not answered in time");
    a_heat_when_cold: assert property (temp_code == 8'hff |=> heater_on)
        else $error("heater off while roll is cold");
    a_heat_off_hot: assert property (temp_code <= 8'ha4 |=> !heater_on)
        else $error("heater on above setpoint");
    a_hv_with_motor: assert property (charge_voltage_on |-> transfer_voltage_on && main_motor_on)
        else $error("charge on without transfer or motor");
    a_open_stops_hv: assert property (s_open |-> ##[1:2] !charge_voltage_on)
        else $error("high voltage kept on with interlock open");
    a_no_ready_hot: assert property (temp_code <= 8'h6e |=> !ready)
        else $error("ready while overheated");
    a_routine_bounded: assert property (run_ff <= RECOVER_CYCLES + CLEAN_CYCLES + 4)
        else $error("routine ran too long");
endmodule // fecr_ctrl_props

bind fecr_ctrl fecr_ctrl_props #(.RECOVER_CYCLES(RECOVER_CYCLES), .CLEAN_CYCLES(CLEAN_CYCLES)) i_props (
    .core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .temp_code, .interlock_closed,
    .heater_on, .main_motor_on, .charge_voltage_on, .transfer_voltage_on, .ready);

/* dv/fecr_roll_model.sv */
// Purpose: Heat roll and thermistor model facing the controller.
// Assumes: One code step per four clocks of heating or cooling.
// Notes: The bench may pin the code to reach exact threshold cases.
`timescale 1ns/10ps
module fecr_roll_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // Heater drive and bench override.
    input wire logic heater_on,
    input wire logic pin_en,
    input wire logic [7:0] pin_code,
    // Thermistor code.
    output logic [7:0] temp_code
);
    logic [7:0] sim_ff;
    logic [1:0] div_ff;
    // A hotter roll gives a smaller code, saturating at both ends.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sim_ff <= 8'hff;
            div_ff <= 2'h0;
        end else begin
            div_ff <= div_ff + 2'h1;
            if (div_ff == 2'h3 && heater_on && sim_ff != 8'h00) begin
                sim_ff <= sim_ff - 8'h01;
            end else if (div_ff == 2'h3 && !heater_on && sim_ff != 8'hff) begin
                sim_ff <= sim_ff + 8'h01;
            end
        end
    end
    assign temp_code = pin_en ? pin_code : sim_ff;
endmodule // fecr_roll_model

/* dv/fecr_ctrl_tb.sv */
// Purpose: Self-checking bench for the fuser and engine routine controller.
// Assumes: Routines shortened to 20 and 30 cycles.
// Notes: Register access goes through classic Wishbone cycles.
`timescale 1ns/10ps
module fecr_ctrl_tb;
    import fecr_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, temp_code, pin_code = 8'hff;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic interlock_closed = 1'b1, cassette_present = 1'b1, exit_actuated = 1'b0, reg_actuated = 1'b0;
    logic cartridge_unit_switch = 1'b0, print_active = 1'b0, continuous_print = 1'b0, pin_en = 1'b0;
    logic wb_ack_o, heater_on, main_motor_on, charge_voltage_on, transfer_voltage_on, ready;
    int fails = 0, total_checks = 0;
    localparam logic [7:0] RADR [6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    localparam logic [31:0] RVAL [6] = '{32'h3, 32'hac, 32'ha4, 32'h6e, 32'hc0, 32'h0};
    localparam logic [7:0] HCODE [6] = '{8'haf, 8'hae, 8'hac, 8'hae, 8'hb2, 8'hb3};
    localparam logic HEXP [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    fecr_ctrl #(.RECOVER_CYCLES(20), .CLEAN_CYCLES(30)) i_dut (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .temp_code, .interlock_closed,
        .cassette_present, .exit_actuated, .reg_actuated, .cartridge_unit_switch, .print_active,
        .continuous_print, .heater_on, .main_motor_on, .charge_voltage_on, .transfer_voltage_on, .ready);
    fecr_roll_model i_roll (.core_clk, .resetn, .heater_on, .pin_en, .pin_code, .temp_code);
    always #50 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        chk({31'h0, wb_ack_o}, 32'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic st(input int b, input logic e);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, q[b]}, {31'h0, e});
    endtask
    task automatic heat(input logic [7:0] c, input logic e);
        pin_code <= c;
        step(3);
        chk({31'h0, heater_on}, {31'h0, e});
    endtask
    task automatic wait_chg(input logic v);
        int n;
        n = 0;
        while (charge_voltage_on !== v && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, charge_voltage_on}, {31'h0, v});
    endtask
    task automatic close_out;
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        step(3);
        resetn <= 1'b1;
        step(4);
        st(ST_RECOVER_BIT, 1'b1);
        st(ST_WARMUP_BIT, 1'b1);
        st(ST_MOTOR_BIT, 1'b1);
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, RADR[i], 32'h0);
            chk(q, RVAL[i]);
        end
        wait_chg(1'b0);
        chk({31'h0, main_motor_on}, 32'h1);
        st(ST_WARMUP_BIT, 1'b1);
        for (int i = 0; i < 3000 && ready !== 1'b1; i++) step(1);
        chk({31'h0, ready}, 32'h1);
        st(ST_WARMDONE_BIT, 1'b1);
        st(ST_WARMUP_BIT, 1'b0);
        pin_en <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (i == 4) wb(1'b1, ADDR_MEM_BASE, 32'hb0);
            heat(HCODE[i], HEXP[i]);
        end
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk({24'h0, q[7:0]}, 32'hb3);
        print_active <= 1'b1;
        heat(8'ha5, 1'b1);
        heat(8'ha4, 1'b0);
        heat(8'h6e, 1'b0);
        st(ST_OVERHEAT_BIT, 1'b1);
        pin_code <= 8'hc0;
        st(ST_SUBCOOL_BIT, 1'b1);
        pin_code <= 8'hb0;
        print_active <= 1'b0;
        wait_chg(1'b1);
        chk({30'h0, main_motor_on, transfer_voltage_on}, 32'h3);
        step(5);
        interlock_closed <= 1'b0;
        wait_chg(1'b0);
        st(ST_HALT_BIT, 1'b1);
        reg_actuated <= 1'b1;
        interlock_closed <= 1'b1;
        wait_chg(1'b1);
        st(ST_RECOVER_BIT, 1'b0);
        reg_actuated <= 1'b0;
        wait_chg(1'b0);
        step(3);
        chk({31'h0, charge_voltage_on}, 32'h0);
        for (int i = 0; i < 3; i++) begin
            interlock_closed <= (i != 0);
            cassette_present <= (i != 1);
            exit_actuated <= (i == 2);
            step(2);
            interlock_closed <= 1'b1;
            cassette_present <= 1'b1;
            exit_actuated <= 1'b0;
            wait_chg(1'b1);
            chk({30'h0, main_motor_on, transfer_voltage_on}, 32'h3);
            st(ST_RECOVER_BIT, 1'b1);
            wait_chg(1'b0);
        end
        print_active <= 1'b1;
        continuous_print <= 1'b1;
        step(3);
        print_active <= 1'b0;
        step(5);
        chk({31'h0, charge_voltage_on}, 32'h0);
        continuous_print <= 1'b0;
        wb(1'b1, ADDR_CTRL, 32'h1);
        cartridge_unit_switch <= 1'b1;
        step(5);
        chk({31'h0, charge_voltage_on}, 32'h0);
        cartridge_unit_switch <= 1'b0;
        wb(1'b1, ADDR_CTRL, 32'h3);
        cartridge_unit_switch <= 1'b1;
        wait_chg(1'b1);
        cartridge_unit_switch <= 1'b0;
        wait_chg(1'b0);
        close_out;
    end
    initial begin
        step(20000);
        fails++;
        close_out;
    end
endmodule // fecr_ctrl_tb
